// file: rtl/light_sensor_params.svh
// Register map, field positions and reset values of the light sensor readout
`ifndef LIGHT_SENSOR_PARAMS_SVH
`define LIGHT_SENSOR_PARAMS_SVH

`define TARGET_ADDR 7'h29
`define OFF_CTRL 8'h80
`define OFF_TIMING 8'h85
`define OFF_CH1_LO 8'h88
`define OFF_CH1_HI 8'h89
`define OFF_CH0_LO 8'h8a
`define OFF_CH0_HI 8'h8b
`define OFF_STATUS 8'h8c
`define RST_CTRL 8'h00
`define RST_TIMING 8'h03
`define CTRL_ACTIVE_BIT 0
`define CTRL_GAIN_LSB 2
`define TIMING_RATE_LSB 0
`define TIMING_INT_LSB 3
`define STAT_VALID_BIT 7
`define STAT_GAIN_LSB 4
`define STAT_FRESH_BIT 2
`define BITS_PER_BYTE 4'h8

`endif

// file: rtl/light_sensor_pkg.sv
// Types shared by the light sensor readout and its surroundings
package light_sensor_pkg;

	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_RX_ADDR = 8'h02,
		ST_RX_PTR = 8'h04,
		ST_RX_DATA = 8'h08,
		ST_ACK = 8'h10,
		ST_TX = 8'h20,
		ST_TX_ACK = 8'h40,
		ST_TX_LOAD = 8'h80
	} bus_state_t;

	// One finished measurement from the conversion core
	typedef struct packed {
		logic invalid;
		logic [2:0] gain;
		logic [15:0] chan_one_count;
		logic [15:0] chan_zero_count;
	} result_t;

	// Settings handed to the conversion core
	typedef struct packed {
		logic active;
		logic [2:0] gain_divisor;
		logic [2:0] integration_factor;
		logic [2:0] repeat_code;
	} meas_cfg_t;

	typedef struct packed {
		logic [1:0] sync1;
		logic [1:0] sync2;
		logic [1:0] sync3;
		logic scl;
		logic sda;
		bus_state_t state;
		bus_state_t after_ack;
		logic [7:0] shift;
		logic [3:0] bit_cnt;
		logic reading;
		logic [7:0] ptr;
		logic sda_oe;
		logic sda_out;
		logic [7:0] operating_control;
		logic [7:0] measure_timing;
		result_t shown;
		result_t pending;
		logic pending_full;
		logic locked;
		logic fresh_result_flag;
	} readout_st_t;

endpackage

// file: rtl/light_sensor_reg_readout.sv
// I2C register readout and configuration path of an ambient light sensor
//
// Summary of operation
// R01: The target answers only at 7-bit address 0x29; other addresses get no ack.
// R02: The operating control register at 0x80 resets to 0x00, in standby.
// R03: Control 0x01 starts measuring at gain 1x and 0x1D at gain 96x.
// R04: The timing register at 0x85 resets to 0x03, 100 ms over 500 ms.
// R05: Timing 0x12 selects 200/200 ms and 0x1B selects 400/500 ms.
// R06: The host reads the four result bytes as a group, low byte first.
// R07: Second-channel count sits low at 0x88, high at 0x89, read first.
// R08: First-channel count sits low at 0x8A and high at 0x8B.
// R09: The host builds each count as high byte shifted by eight OR low.
// R10: Status at 0x8C is read only and bit mask 0x04 marks a fresh result.
// R11: Status bit mask 0x80 set means the result is unusable to the host.
// R12: Gains 1, 2, 4, 8, 48 and 96 are offered, two codes between unused.
// R13: Integration runs 50 to 400 ms in 50 ms steps, eight settings.
// R14: A result read freezes all four bytes until 0x8B is read; the newest waits.
// R15: The fresh flag sets when a result is stored and clears when read.
// R16: Status gain field reports the stored result's gain code.
// R17: Writes to read-only registers are acknowledged and change nothing.
`timescale 1ns/1ps
`include "light_sensor_params.svh"

module light_sensor_reg_readout (
	input wire logic clk,
	input wire logic srst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic core_done,
	input wire light_sensor_pkg::result_t core_result,
	output light_sensor_pkg::meas_cfg_t meas_cfg
);
	import light_sensor_pkg::*;

	readout_st_t st;
	readout_st_t next_st;

	logic [1:0] pins;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic [7:0] read_byte;
	logic in_data;
	logic [7:0] status_byte;
	logic [1:0] pin_agree;
	logic addr_match;
	logic last_data;

	assign pins = {sda_in, scl_in};

	// One agreement test per bus pin; a one-clock glitch never sits in
	// both late stages at once, so it cannot fake a start or a stop
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : g_pin
			assign pin_agree[g] = st.sync2[g] == st.sync3[g];
		end
	endgenerate

	// Open drain: the line is only ever pulled low
	assign sda_out = st.sda_out;
	assign sda_oe = st.sda_oe;
	// Codes pass through untouched; the core scales by gain and period
	// Unused gain codes are kept as written and left to the core
	assign meas_cfg = '{
		active: st.operating_control[`CTRL_ACTIVE_BIT], // see R03
		gain_divisor: st.operating_control[`CTRL_GAIN_LSB +: 3], // see R12
		integration_factor: st.measure_timing[`TIMING_INT_LSB +: 3], // see R13
		repeat_code: st.measure_timing[`TIMING_RATE_LSB +: 3] // see R05
	};

	// Status byte: validity, gain of stored result, fresh flag
	always_comb
	begin
		// Bit 3 stays low: this block raises no interrupt of its own
		status_byte = 8'h00;
		status_byte[`STAT_VALID_BIT] = st.shown.invalid; // see R11
		status_byte[`STAT_GAIN_LSB +: 3] = st.shown.gain; // see R16
		status_byte[`STAT_FRESH_BIT] = st.fresh_result_flag; // see R10
	end

	// Read multiplexer, unmapped offsets read as zero
	// Identity offsets are not decoded, so they read as zero as well
	always_comb
	begin
		if (st.ptr == `OFF_CTRL)
			read_byte = st.operating_control;
		else if (st.ptr == `OFF_TIMING)
			read_byte = st.measure_timing;
		else if (st.ptr == `OFF_CH1_LO)
			read_byte = st.shown.chan_one_count[7:0]; // see R07
		else if (st.ptr == `OFF_CH1_HI)
			read_byte = st.shown.chan_one_count[15:8]; // see R07
		else if (st.ptr == `OFF_CH0_LO)
			read_byte = st.shown.chan_zero_count[7:0]; // see R08
		else if (st.ptr == `OFF_CH0_HI)
			read_byte = st.shown.chan_zero_count[15:8]; // see R08
		else if (st.ptr == `OFF_STATUS)
			read_byte = status_byte; // see R10
		else
			read_byte = 8'h00;
	end

	// The four result bytes; loading any of them for the host takes the lock
	assign in_data = (st.ptr >= `OFF_CH1_LO) && (st.ptr <= `OFF_CH0_HI);
	assign addr_match = st.shift[7:1] == `TARGET_ADDR; // see R01
	assign last_data = st.ptr == `OFF_CH0_HI; // see R14

	always_comb
	begin
		next_st = st;
		scl_rise = 1'b0;
		scl_fall = 1'b0;
		start_seen = 1'b0;
		stop_seen = 1'b0;

		// Three-stage synchroniser; a level counts once stages two and three agree
		next_st.sync1 = pins;
		next_st.sync2 = st.sync1;
		next_st.sync3 = st.sync2;
		if (pin_agree[0])
			next_st.scl = st.sync3[0];
		if (pin_agree[1])
			next_st.sda = st.sync3[1];

		scl_rise = next_st.scl && !st.scl;
		scl_fall = !next_st.scl && st.scl;
		start_seen = st.scl && next_st.scl && st.sda && !next_st.sda;
		stop_seen = st.scl && next_st.scl && !st.sda && next_st.sda;

		// Newest result waits here while the shown bytes are frozen
		if (core_done)
		begin
			next_st.pending = core_result; // see R14
			next_st.pending_full = 1'b1;
		end

		if (start_seen)
		begin
			next_st.state = ST_RX_ADDR;
			next_st.bit_cnt = 4'h0;
			next_st.sda_oe = 1'b0;
		end
		else if (stop_seen)
		begin
			next_st.state = ST_IDLE;
			next_st.sda_oe = 1'b0;
		end
		else
		begin
			case (st.state)
				// Bits taken on the filtered rise
				ST_RX_ADDR, ST_RX_PTR, ST_RX_DATA:
				begin
					if (scl_rise)
					begin
						next_st.shift = {st.shift[6:0], next_st.sda};
						next_st.bit_cnt = st.bit_cnt + 4'h1;
					end
					else if (scl_fall && st.bit_cnt == `BITS_PER_BYTE)
					begin
						next_st.bit_cnt = 4'h0;
						next_st.state = ST_ACK;
						next_st.sda_oe = 1'b1;
						if (st.state == ST_RX_ADDR)
						begin
							next_st.reading = st.shift[0];
							next_st.after_ack = st.shift[0] ? ST_TX : ST_RX_PTR;
							if (!addr_match) // see R01
							begin
								next_st.state = ST_IDLE;
								next_st.sda_oe = 1'b0;
							end
						end
						else if (st.state == ST_RX_PTR)
						begin
							next_st.ptr = st.shift;
							next_st.after_ack = ST_RX_DATA;
						end
						else
						begin
							// Read-only and unmapped offsets still get an ack
							if (st.ptr == `OFF_CTRL)
								next_st.operating_control = st.shift; // see R03
							else if (st.ptr == `OFF_TIMING)
								next_st.measure_timing = st.shift; // see R05
							next_st.ptr = st.ptr + 8'h01; // see R17
							next_st.after_ack = ST_RX_DATA;
						end
					end
				end

				// Line held for the ninth clock
				ST_ACK:
				begin
					if (scl_fall)
					begin
						next_st.state = st.after_ack;
						next_st.sda_oe = 1'b0;
						if (st.after_ack == ST_TX)
						begin
							next_st.shift = read_byte;
							next_st.sda_oe = !read_byte[7];
							if (in_data)
								next_st.locked = 1'b1; // see R14
						end
					end
				end

				// A bit changes only early in the low phase
				ST_TX:
				begin
					if (scl_rise)
						next_st.bit_cnt = st.bit_cnt + 4'h1;
					else if (scl_fall)
					begin
						if (st.bit_cnt == `BITS_PER_BYTE)
						begin
							next_st.bit_cnt = 4'h0;
							next_st.sda_oe = 1'b0;
							next_st.state = ST_TX_ACK;
							next_st.ptr = st.ptr + 8'h01;
							if (in_data)
								next_st.fresh_result_flag = 1'b0; // see R15
							if (last_data)
								next_st.locked = 1'b0; // see R14
						end
						else
						begin
							next_st.shift = {st.shift[6:0], 1'b0};
							next_st.sda_oe = !st.shift[6];
						end
					end
				end

				ST_TX_ACK:
				begin
					// A not-acknowledge ends the read; wait for stop or start
					if (scl_rise)
						next_st.state = next_st.sda ? ST_IDLE : ST_TX_LOAD;
				end

				ST_TX_LOAD:
				begin
					if (scl_fall)
					begin
						next_st.state = ST_TX;
						next_st.shift = read_byte;
						next_st.sda_oe = !read_byte[7];
						if (in_data)
							next_st.locked = 1'b1; // see R14
					end
				end

				ST_IDLE:
				begin
					// Released until the next start
					next_st.sda_oe = 1'b0;
					next_st.bit_cnt = 4'h0;
				end

				default:
				begin
					next_st.sda_oe = 1'b0;
				end
			endcase
		end

		// Store after the clear above so a new result always wins. A lock
		// taken in this very cycle counts too: the byte just loaded for the
		// host came from the old result, and its partner bytes must match.
		if (st.pending_full && !next_st.locked)
		begin
			next_st.shown = st.pending; // see R14
			next_st.pending_full = core_done;
			next_st.fresh_result_flag = 1'b1; // see R15
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			// Filter stages start idle-high, so reset shows no false edge
			st <= '0;
			st.sync1 <= 2'h3;
			st.sync2 <= 2'h3;
			st.sync3 <= 2'h3;
			st.scl <= 1'b1;
			st.sda <= 1'b1;
			st.state <= ST_IDLE;
			st.after_ack <= ST_IDLE;
			st.operating_control <= `RST_CTRL; // see R02
			st.measure_timing <= `RST_TIMING; // see R04
		end
		else
		begin
			st <= next_st;
		end
	end

endmodule

// file: test/readout_asserts.sv
// Pin timing and reset checks of the light sensor readout
`timescale 1ns/1ps
module readout_asserts (
	input wire logic clk,
	input wire logic srst,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic core_done,
	input wire light_sensor_pkg::result_t core_result,
	input wire light_sensor_pkg::meas_cfg_t meas_cfg
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	property p_od; sda_out == 1'b0; endproperty
	a_od: assert property (p_od) else $error("sda high");
	property p_rst;
		$fell(srst) |-> meas_cfg == 10'h003 && !sda_oe;
	endproperty
	a_rst: assert property (p_rst) else $error("reset");
	property p_cfg; scl_in [*4] |-> $stable(meas_cfg); endproperty
	a_cfg: assert property (p_cfg) else $error("cfg");
	property p_rise; $rose(sda_oe) |-> !scl_in; endproperty
	a_rise: assert property (p_rise) else $error("rise");
	property p_fall; $fell(sda_oe) |-> !scl_in; endproperty
	a_fall: assert property (p_fall) else $error("fall");
	property p_hold; scl_in [*4] |-> $stable(sda_oe); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	// The pin filter delays every answer, so sda never follows scl at once
	property p_lagr; $rose(sda_oe) |-> !$past(scl_in, 2); endproperty
	a_lagr: assert property (p_lagr) else $error("lag");
	property p_lagf; $fell(sda_oe) |-> !$past(scl_in, 2); endproperty
	a_lagf: assert property (p_lagf) else $error("lag");
endmodule
bind light_sensor_reg_readout readout_asserts i_readout_asserts (.clk,
	.srst, .scl_in, .sda_in, .sda_out, .sda_oe, .core_done,
	.core_result, .meas_cfg);

// file: test/host_model.sv
// Behavioural I2C host driving the readout's bus pins
`timescale 1ns/1ps
module host_model (
	input wire logic clk,
	input wire logic sda_oe,
	output logic scl,
	output logic sda
);
	logic sda_drv = 1'b1;
	// Pull-up wire: host or target may pull low; a line freed by both reads high
	assign sda = sda_drv & ~sda_oe;
	initial scl = 1'b1;
	task automatic ph(input logic c, d, input int n);
		scl <= c;
		sda_drv <= d;
		repeat (n) @(posedge clk);
	endtask
	// Start when s is 1, stop when 0
	task automatic cond(input logic s);
		ph(1'b0, sda_drv, 2);
		ph(1'b0, s, 4);
		ph(1'b1, s, 8);
		ph(1'b1, ~s, 8);
	endtask
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--)
		begin
			ph(1'b0, sda_drv, 2);
			ph(1'b0, d[i], 6);
			ph(1'b1, d[i], 8);
			q[i] = sda;
		end
	endtask
	task automatic wr(input logic [7:0] a, p, d, output logic ok);
		logic [8:0] q0, q1, q2;
		cond(1'b1);
		xfer({a, 1'b1}, q0);
		xfer({p, 1'b1}, q1);
		xfer({d, 1'b1}, q2);
		cond(1'b0);
		ok = !(q0[0] | q1[0] | q2[0]);
	endtask
	task automatic rd(input logic [7:0] p, output logic [7:0] v);
		logic [8:0] q;
		cond(1'b1);
		xfer({8'h52, 1'b1}, q);
		xfer({p, 1'b1}, q);
		cond(1'b1);
		xfer({8'h53, 1'b1}, q);
		xfer(9'h1ff, q);
		cond(1'b0);
		v = q[8:1];
	endtask
endmodule

// file: test/testbench.sv
// Self-checking bench of the light sensor readout
`timescale 1ns/1ps
module testbench;
	import light_sensor_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic core_done = 1'b0;
	result_t core_result = '0;
	logic scl, sda, sda_out, sda_oe, ack;
	logic [7:0] q, lo;
	meas_cfg_t meas_cfg;
	int failures = 0;
	int n_tests = 0;
`define CHK(a, e) \
	begin n_tests++; if ((a) !== (e)) begin failures++; \
	$display("wrong value at %0t: %h %h", $time, a, e); end end
	always #50 clk = ~clk;
	light_sensor_reg_readout i_light_sensor_reg_readout (.clk(clk),
		.srst(srst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .core_done(core_done),
		.core_result(core_result), .meas_cfg(meas_cfg));
	host_model i_host_model (.clk(clk), .sda_oe(sda_oe), .scl(scl),
		.sda(sda));
	task automatic close_out;
		$display("failures %0d of %0d", failures, n_tests);
		if (failures == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic store(input result_t r);
		core_result <= r;
		core_done <= 1'b1;
		@(posedge clk);
		core_done <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic rchk(input logic [7:0] p, e);
		i_host_model.rd(p, q);
		`CHK(q, e)
	endtask
	task automatic pair(input logic [7:0] p, input logic [15:0] e);
		i_host_model.rd(p, lo);
		i_host_model.rd(p + 8'h01, q);
		`CHK({q, lo}, e)
	endtask
	task automatic t_reset;
		`CHK(meas_cfg, 10'h003)
		rchk(8'h80, 8'h00);
		rchk(8'h85, 8'h03);
	endtask
	task automatic t_config;
		logic [15:0] w [4] = '{16'h8001, 16'h801d, 16'h8512, 16'h851b};
		foreach (w[i])
		begin
			i_host_model.wr(8'h52, w[i][15:8], w[i][7:0], ack);
			`CHK(ack, 1'b1)
			rchk(w[i][15:8], w[i][7:0]);
		end
		`CHK(meas_cfg, 10'h3db)
		i_host_model.wr(8'h50, 8'h80, 8'h00, ack);
		`CHK(ack, 1'b0)
		`CHK(meas_cfg, 10'h3db)
	endtask
	task automatic t_result;
		store({1'b1, 3'b110, 16'h1234, 16'habcd});
		rchk(8'h8c, 8'he4);
		pair(8'h88, 16'h1234);
		pair(8'h8a, 16'habcd);
		rchk(8'h8c, 8'he0);
	endtask
	// A second result lands mid-read and must wait until 0x8B is read
	task automatic t_lock;
		store({1'b0, 3'b111, 16'h5566, 16'h7788});
		rchk(8'h88, 8'h66);
		store({1'b0, 3'b001, 16'h1111, 16'h2222});
		rchk(8'h89, 8'h55);
		pair(8'h8a, 16'h7788);
		rchk(8'h8c, 8'h14);
		pair(8'h88, 16'h1111);
	endtask
	task automatic t_ro;
		i_host_model.wr(8'h52, 8'h8c, 8'hff, ack);
		`CHK(ack, 1'b1)
		i_host_model.wr(8'h52, 8'h8b, 8'h00, ack);
		`CHK(ack, 1'b1)
		pair(8'h8a, 16'h2222);
		rchk(8'h8c, 8'h10);
	endtask
	initial
	begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		t_reset();
		t_config();
		t_result();
		t_lock();
		t_ro();
		close_out();
	end
endmodule
